/* tbo_buf.sv */
// Small valid/ready FIFO between the trace intake and the buffer writer.
// Assumes the synchronised reset and a shared clock enable.
`timescale 1ns/100ps
module tbo_buf #(
  parameter int WIDTH = 64,
  parameter int DEPTH = 2
) (
  input  wire logic             clk_sys_i,
  input  wire logic             rst_n_i,
  input  wire logic             ce_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);

  localparam int PW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_ff [DEPTH];
  logic [PW-1:0]    wr_ff;
  logic [PW-1:0]    rd_ff;
  logic [PW:0]      cnt_ff;
  logic [PW-1:0]    nxt_wr;
  logic [PW-1:0]    nxt_rd;
  logic [PW:0]      nxt_cnt;
  logic             push;
  logic             pop;

  // Honest full/empty; a full buffer back-pressures the intake
  assign in_ready_o  = ce_i && (cnt_ff != (PW+1)'(DEPTH));
  assign out_valid_o = ce_i && (cnt_ff != '0);
  assign out_data_o  = mem_ff[rd_ff];
  assign push        = in_valid_i && in_ready_o;
  assign pop         = out_valid_o && out_ready_i;

  // Pointer wrap at the depth, not at a power of two
  always_comb begin
    nxt_wr  = wr_ff;
    nxt_rd  = rd_ff;
    nxt_cnt = cnt_ff;
    if (push) begin
      nxt_wr = (wr_ff == PW'(DEPTH - 1)) ? '0 : wr_ff + PW'(1);
    end
    if (pop) begin
      nxt_rd = (rd_ff == PW'(DEPTH - 1)) ? '0 : rd_ff + PW'(1);
    end
    if (push && !pop) begin
      nxt_cnt = cnt_ff + (PW+1)'(1);
    end else if (pop && !push) begin
      nxt_cnt = cnt_ff - (PW+1)'(1);
    end
  end

  // Pointer and count registers
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_ff  <= '0;
      rd_ff  <= '0;
      cnt_ff <= '0;
    end else begin
      wr_ff  <= nxt_wr;
      rd_ff  <= nxt_rd;
      cnt_ff <= nxt_cnt;
    end
  end

  // Storage needs no reset; count gates validity
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      mem_ff[wr_ff] <= in_data_i;
    end
  end

endmodule : tbo_buf

/* tbo_map.svh */
// Encodings and reset values for the trace buffer owner/regime decoder.
// Assumes inclusion by bare name from the top design module.
`ifndef TBO_MAP_SVH
`define TBO_MAP_SVH

// ****************************************************************
// Control field encodings
// ****************************************************************
`define TBO_LEVEL_OWNER_EL2   2'h0      // Level owner value selecting EL2 ownership
`define TBO_EL3               2'h3      // Exception level codes
`define TBO_EL2               2'h2
`define TBO_EL1               2'h1
`define TBO_EL0               2'h0

// ****************************************************************
// Reset values and parameter defaults
// ****************************************************************
`define TBO_TAG_RST           16'h0000  // Address space and VM tags
`define TBO_ALLOW_RST         4'h0      // All levels prohibited
`define TBO_DATA_W_DEF        64        // Default trace word width
`define TBO_TAG_W_DEF         16        // Default tag width
`define TBO_BUF_DEPTH_DEF     2         // Two-entry trace buffer

`endif

/* tbo_pkg.sv */
// Types shared by the trace buffer owner/regime decoder.
// Assumes tbo_map.svh is on the include path.
package tbo_pkg;

  // ****************************************************************
  // Owning translation regime
  // ****************************************************************
  typedef enum logic [2:0] {
    TBO_RGM_DISABLED = 3'h0,
    TBO_RGM_S_EL10   = 3'h1,
    TBO_RGM_S_EL2    = 3'h2,
    TBO_RGM_S_EL20   = 3'h3,
    TBO_RGM_NS_EL10  = 3'h4,
    TBO_RGM_NS_EL2   = 3'h5,
    TBO_RGM_NS_EL20  = 3'h6
  } tbo_regime_type;

  // ****************************************************************
  // Meaning of the buffer pointers
  // ****************************************************************
  typedef enum logic [1:0] {
    TBO_ADDR_NONE = 2'h0,
    TBO_ADDR_VA   = 2'h1,
    TBO_ADDR_IPA  = 2'h2,
    TBO_ADDR_PA   = 2'h3
  } tbo_addr_kind_type;

endpackage : tbo_pkg

/* tbo_rst_sync.sv */
// Reset release synchroniser: asynchronous assert, two-flop release.
// Assumes a free-running clock; the clock enable also holds release.
`timescale 1ns/100ps
module tbo_rst_sync (
  input  wire logic clk_sys_i,
  input  wire logic rst_n_i,
  input  wire logic ce_i,
  output logic      rst_n_o
);

  logic meta_ff;
  logic sync_ff;
  logic nxt_meta;
  logic nxt_sync;

  // Shift a one in behind the release
  always_comb begin
    nxt_meta = ce_i ? 1'b1 : meta_ff;
    nxt_sync = ce_i ? meta_ff : sync_ff;
  end

  // Constants only under reset
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      meta_ff <= 1'b0;
      sync_ff <= 1'b0;
    end else begin
      meta_ff <= nxt_meta;
      sync_ff <= nxt_sync;
    end
  end

  assign rst_n_o = sync_ff;

endmodule : tbo_rst_sync

/* tbo_top.sv */
// Trace buffer owner decode: owning regime, pointer meaning, tags and
// prohibited trace regions, plus the trace intake with discard.
// Assumes all control inputs are the effective values, synchronous to
// clk_sys_i, and that the downstream writer applies back-pressure.
`timescale 1ns/100ps
`include "tbo_map.svh"
module tbo_top #(
  parameter int DATA_W    = `TBO_DATA_W_DEF,
  parameter int TAG_W     = `TBO_TAG_W_DEF,
  parameter int BUF_DEPTH = `TBO_BUF_DEPTH_DEF
) (
  input  wire logic              clk_sys_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  // Effective control values
  input  wire logic              enable_i,
  input  wire logic              el3_present_i,
  input  wire logic              el2_present_i,
  input  wire logic              pe_nonsecure_i,
  input  wire logic [1:0]        pe_level_i,
  input  wire logic              pointer_phys_select_i,
  input  wire logic              stage2_on_i,
  input  wire logic              host_trap_general_i,
  input  wire logic              host_el2_mode_i,
  input  wire logic [1:0]        buffer_security_owner_i,
  input  wire logic [1:0]        buffer_level_owner_i,
  input  wire logic              secure_hyp_enable_i,
  input  wire logic              world_select_i,
  input  wire logic              secure_trace_enable_i,
  input  wire logic              hyp_level_trace_allow_i,
  input  wire logic              kernel_level_trace_allow_i,
  input  wire logic              user_level_host_trace_allow_i,
  input  wire logic              user_level_trace_allow_i,
  input  wire logic [TAG_W-1:0]  kernel_addr_space_tag_i,
  input  wire logic [TAG_W-1:0]  hyp_addr_space_tag_i,
  input  wire logic [TAG_W-1:0]  vm_tag_i,
  // Trace intake from the trace unit
  input  wire logic              trc_valid_i,
  output logic                   trc_ready_o,
  input  wire logic [DATA_W-1:0] trc_data_i,
  // Towards the buffer writer
  output logic                   wr_valid_o,
  input  wire logic              wr_ready_i,
  output logic      [DATA_W-1:0] wr_data_o,
  // Decoded state
  output tbo_pkg::tbo_regime_type    regime_o,
  output logic                       owner_nonsecure_o,
  output logic                       owner_el2_o,
  output tbo_pkg::tbo_addr_kind_type addr_kind_o,
  output logic                       stage1_on_o,
  output logic                       stage2_xlat_o,
  output logic      [TAG_W-1:0]      addr_space_tag_o,
  output logic      [TAG_W-1:0]      vm_tag_o,
  output logic                       world_mismatch_o,
  output logic      [3:0]            level_allow_o,
  output logic                       trace_prohibited_o,
  output logic                       xlat_prefetch_allow_o,
  output logic                       alt_route_allow_o,
  output logic                       discard_o
);

  // ****************************************************************
  // Reset release
  // ****************************************************************
  logic rst_sync_n;

  tbo_rst_sync u_rst_sync (
    .clk_sys_i (clk_sys_i),
    .rst_n_i   (rst_n_i),
    .ce_i      (ce_i),
    .rst_n_o   (rst_sync_n)
  );

  // ****************************************************************
  // Owner decode (combinational, every cycle)
  // ****************************************************************
  logic                       own_ns;
  logic                       el2_on;
  logic                       own_el2;
  logic                       lvl_own_el2;
  logic                       mismatch;
  tbo_pkg::tbo_regime_type    rgm;
  tbo_pkg::tbo_addr_kind_type akind;
  logic                       s2_on;
  logic [TAG_W-1:0]           addr_space_tag;
  logic [TAG_W-1:0]           vm_tag;

  always_comb begin
    lvl_own_el2 = (buffer_level_owner_i == `TBO_LEVEL_OWNER_EL2);
    own_ns = buffer_security_owner_i[1] || (!el3_present_i && pe_nonsecure_i);
    mismatch = (own_ns != world_select_i);
    el2_on = el2_present_i && (own_ns || secure_hyp_enable_i);
    own_el2 = el2_on && lvl_own_el2;
    rgm = tbo_pkg::TBO_RGM_DISABLED;
    akind = tbo_pkg::TBO_ADDR_NONE;
    s2_on = 1'b0;
    addr_space_tag = `TBO_TAG_RST;
    vm_tag = `TBO_TAG_RST;
    if (enable_i) begin
      unique case ({own_ns, own_el2, host_el2_mode_i})
        3'b000, 3'b001: rgm = tbo_pkg::TBO_RGM_S_EL10;
        3'b010:         rgm = tbo_pkg::TBO_RGM_S_EL2;
        3'b011:         rgm = tbo_pkg::TBO_RGM_S_EL20;
        3'b100, 3'b101: rgm = tbo_pkg::TBO_RGM_NS_EL10;
        3'b110:         rgm = tbo_pkg::TBO_RGM_NS_EL2;
        3'b111:         rgm = tbo_pkg::TBO_RGM_NS_EL20;
      endcase
      if (!own_el2) begin
        if (!pointer_phys_select_i) begin
          akind = tbo_pkg::TBO_ADDR_VA;
          addr_space_tag  = kernel_addr_space_tag_i;
        end else begin
          akind = tbo_pkg::TBO_ADDR_IPA;
        end
        s2_on = el2_on && stage2_on_i;
        vm_tag  = s2_on ? vm_tag_i : `TBO_TAG_RST;
      end else begin
        if (!pointer_phys_select_i) begin
          akind = tbo_pkg::TBO_ADDR_VA;
          addr_space_tag  = host_el2_mode_i ? hyp_addr_space_tag_i : `TBO_TAG_RST;
        end else begin
          akind = tbo_pkg::TBO_ADDR_PA;
        end
      end
    end
  end

  // ****************************************************************
  // Prohibited trace regions
  // ****************************************************************
  logic       whole_block;
  logic [3:0] allow;
  logic       cur_allow;

  always_comb begin
    whole_block = (world_select_i && !buffer_security_owner_i[1])
               || (!world_select_i && !secure_trace_enable_i)
               || (!world_select_i && buffer_security_owner_i[1]);
    allow = `TBO_ALLOW_RST;
    if (enable_i && !whole_block) begin
      // EL2 only for an EL2 owner
      allow[`TBO_EL2] = own_el2 && hyp_level_trace_allow_i;
      if (!(el2_on && host_trap_general_i)) begin
        allow[`TBO_EL1] = kernel_level_trace_allow_i;
        allow[`TBO_EL0] = user_level_trace_allow_i;
      end else begin
        // Host trapping: EL0 by host allow
        allow[`TBO_EL0] = own_el2 && user_level_host_trace_allow_i;
      end
    end
    allow[`TBO_EL3] = 1'b0;
    cur_allow = allow[pe_level_i] && (pe_nonsecure_i == own_ns);
  end

  // ****************************************************************
  // Trace intake: discard while disabled or prohibited
  // ****************************************************************
  logic buf_in_ready;
  logic buf_push;
  logic drop;

  // Discard path keeps the trace unit moving
  assign drop        = !enable_i || !cur_allow;
  assign buf_push    = trc_valid_i && !drop;
  assign trc_ready_o = ce_i && (drop || buf_in_ready);

  // Two entries so a writer stall loses no word
  tbo_buf #(
    .WIDTH (DATA_W),
    .DEPTH (BUF_DEPTH)
  ) u_buf (
    .clk_sys_i   (clk_sys_i),
    .rst_n_i     (rst_sync_n),
    .ce_i        (ce_i),
    .in_valid_i  (buf_push),
    .in_ready_o  (buf_in_ready),
    .in_data_i   (trc_data_i),
    .out_valid_o (wr_valid_o),
    .out_ready_i (wr_ready_i),
    .out_data_o  (wr_data_o)
  );

  // ****************************************************************
  // Registered decode outputs
  // ****************************************************************
  tbo_pkg::tbo_regime_type    regime_ff;
  tbo_pkg::tbo_addr_kind_type akind_ff;
  logic                       own_ns_ff;
  logic                       own_el2_ff;
  logic                       s1_ff;
  logic                       s2_ff;
  logic [TAG_W-1:0]           addr_space_tag_ff;
  logic [TAG_W-1:0]           vm_tag_ff;
  logic                       mism_ff;
  logic [3:0]                 allow_ff;
  logic                       prohib_ff;
  logic                       en_ff;
  logic                       discard_ff;

  tbo_pkg::tbo_regime_type    nxt_regime;
  tbo_pkg::tbo_addr_kind_type nxt_akind;
  logic                       nxt_own_ns;
  logic                       nxt_own_el2;
  logic                       nxt_s1;
  logic                       nxt_s2;
  logic [TAG_W-1:0]           nxt_addr_space_tag;
  logic [TAG_W-1:0]           nxt_vm_tag;
  logic                       nxt_mism;
  logic [3:0]                 nxt_allow;
  logic                       nxt_prohib;
  logic                       nxt_en;
  logic                       nxt_discard;

  // Hold everything while the clock enable is low
  always_comb begin
    nxt_regime  = regime_ff;
    nxt_akind   = akind_ff;
    nxt_own_ns  = own_ns_ff;
    nxt_own_el2 = own_el2_ff;
    nxt_s1      = s1_ff;
    nxt_s2      = s2_ff;
    nxt_addr_space_tag    = addr_space_tag_ff;
    nxt_vm_tag    = vm_tag_ff;
    nxt_mism    = mism_ff;
    nxt_allow   = allow_ff;
    nxt_prohib  = prohib_ff;
    nxt_en      = en_ff;
    nxt_discard = discard_ff;
    if (ce_i) begin
      nxt_regime  = rgm;
      nxt_akind   = akind;
      // Owner fields forced to zero while disabled
      nxt_own_ns  = enable_i && own_ns;
      nxt_own_el2 = enable_i && own_el2;
      nxt_s1      = akind == tbo_pkg::TBO_ADDR_VA;
      nxt_s2      = s2_on;
      nxt_addr_space_tag    = addr_space_tag;
      nxt_vm_tag    = vm_tag;
      nxt_mism    = enable_i && mismatch;
      nxt_allow   = allow;
      nxt_prohib  = !cur_allow || !enable_i;
      nxt_en      = enable_i;
      nxt_discard = trc_valid_i && drop;
    end
  end

  // Decode registers; reset looks like a disabled unit
  always_ff @(posedge clk_sys_i or negedge rst_sync_n) begin
    if (!rst_sync_n) begin
      regime_ff  <= tbo_pkg::TBO_RGM_DISABLED;
      akind_ff   <= tbo_pkg::TBO_ADDR_NONE;
      own_ns_ff  <= 1'b0;
      own_el2_ff <= 1'b0;
      s1_ff      <= 1'b0;
      s2_ff      <= 1'b0;
      addr_space_tag_ff    <= `TBO_TAG_RST;
      vm_tag_ff    <= `TBO_TAG_RST;
      mism_ff    <= 1'b0;
      allow_ff   <= `TBO_ALLOW_RST;
      prohib_ff  <= 1'b1;
      en_ff      <= 1'b0;
      discard_ff <= 1'b0;
    end else begin
      regime_ff  <= nxt_regime;
      akind_ff   <= nxt_akind;
      own_ns_ff  <= nxt_own_ns;
      own_el2_ff <= nxt_own_el2;
      s1_ff      <= nxt_s1;
      s2_ff      <= nxt_s2;
      addr_space_tag_ff    <= nxt_addr_space_tag;
      vm_tag_ff    <= nxt_vm_tag;
      mism_ff    <= nxt_mism;
      allow_ff   <= nxt_allow;
      prohib_ff  <= nxt_prohib;
      en_ff      <= nxt_en;
      discard_ff <= nxt_discard;
    end
  end

  assign regime_o           = regime_ff;
  assign owner_nonsecure_o  = own_ns_ff;
  assign owner_el2_o        = own_el2_ff;
  assign addr_kind_o        = akind_ff;
  assign stage1_on_o        = s1_ff;
  assign stage2_xlat_o      = s2_ff;
  assign addr_space_tag_o   = addr_space_tag_ff;
  assign vm_tag_o           = vm_tag_ff;
  assign world_mismatch_o   = mism_ff;
  assign level_allow_o      = allow_ff;
  assign trace_prohibited_o = prohib_ff;
  assign xlat_prefetch_allow_o = en_ff;
  assign alt_route_allow_o  = !en_ff;
  assign discard_o          = discard_ff;

endmodule : tbo_top

/* tbo_top_props.sv */
// Concurrent checks on the owner decode and the trace intake.
// Assumes ce_i stays high; bound into tbo_top below.
`timescale 1ns/100ps
module tbo_top_props #(
  parameter int DATA_W = 64
) (
  input wire logic              clk_sys_i,
  input wire logic              rst_n_i,
  input wire logic              enable_i,
  input wire logic              el2_present_i,
  input wire logic              el3_present_i,
  input wire logic              pe_nonsecure_i,
  input wire logic [1:0]        pe_level_i,
  input wire logic              pointer_phys_select_i,
  input wire logic              stage2_on_i,
  input wire logic              host_el2_mode_i,
  input wire logic              host_trap_general_i,
  input wire logic [1:0]        buffer_security_owner_i,
  input wire logic [1:0]        buffer_level_owner_i,
  input wire logic              world_select_i,
  input wire logic              kernel_level_trace_allow_i,
  input wire logic              trc_valid_i,
  input wire logic              trc_ready_o,
  input wire logic              wr_valid_o,
  input wire logic              wr_ready_i,
  input wire logic [DATA_W-1:0] wr_data_o,
  input wire logic [2:0]        regime_o,
  input wire logic              owner_el2_o,
  input wire logic [1:0]        addr_kind_o,
  input wire logic              stage1_on_o,
  input wire logic              stage2_xlat_o,
  input wire logic              trace_prohibited_o,
  input wire logic              xlat_prefetch_allow_o,
  input wire logic              alt_route_allow_o,
  input wire logic              discard_o
);
  logic [1:0] up_cnt_ff;
  logic [1:0] nxt_up_cnt;
  logic       up;

  // ********
  // Settle counter
  // ********
  // Outputs track inputs once the reset release is over
  always_comb begin
    nxt_up_cnt = up ? up_cnt_ff : up_cnt_ff + 2'h1;
  end
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      up_cnt_ff <= 2'h0;
    end else begin
      up_cnt_ff <= nxt_up_cnt;
    end
  end
  assign up = (up_cnt_ff == 2'h3);

  default clocking @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);

  sequence s_drop;
    trc_ready_o ##1 discard_o;
  endsequence

  AST_DIS_DECODE: assert property (up && !$past(enable_i) |->
    regime_o == tbo_pkg::TBO_RGM_DISABLED && addr_kind_o == tbo_pkg::TBO_ADDR_NONE
    && !xlat_prefetch_allow_o && alt_route_allow_o) else $error("disabled decode wrong");
  AST_EL1_REGIME: assert property (up && $past(enable_i && buffer_security_owner_i[1]
    && buffer_level_owner_i[1]) |-> regime_o == tbo_pkg::TBO_RGM_NS_EL10 && !owner_el2_o)
    else $error("EL1 owner regime wrong");
  AST_EL2_REGIME: assert property (up && $past(enable_i && buffer_security_owner_i[1]
    && buffer_level_owner_i == 2'h0 && el2_present_i) |-> regime_o == ($past(host_el2_mode_i)
    ? tbo_pkg::TBO_RGM_NS_EL20 : tbo_pkg::TBO_RGM_NS_EL2)) else $error("EL2 regime wrong");
  AST_IPA: assert property (up && $past(enable_i && buffer_security_owner_i[1]
    && buffer_level_owner_i[1] && pointer_phys_select_i) |-> addr_kind_o ==
    tbo_pkg::TBO_ADDR_IPA && stage2_xlat_o == $past(el2_present_i && stage2_on_i))
    else $error("IPA pointers wrong");
  AST_PHYS: assert property (up && $past(enable_i && buffer_level_owner_i == 2'h0
    && buffer_security_owner_i[1] && el2_present_i && pointer_phys_select_i) |->
    addr_kind_o == tbo_pkg::TBO_ADDR_PA && !stage1_on_o && !stage2_xlat_o)
    else $error("PA pointers translated");
  AST_EL3_PROHIB: assert property (up && $past(pe_level_i) == 2'h3
    |-> trace_prohibited_o) else $error("EL3 traced");
  AST_WORLD_BLOCK: assert property (up && $past(enable_i && world_select_i
    && !buffer_security_owner_i[1]) |-> trace_prohibited_o) else $error("world block missed");
  AST_NS_OWNER: assert property (up && $past(enable_i && buffer_security_owner_i[1]
    && !pe_nonsecure_i) |-> trace_prohibited_o) else $error("secure traced");
  AST_SEC_OWNER: assert property (up && $past(enable_i && !buffer_security_owner_i[1]
    && el3_present_i && pe_nonsecure_i) |-> trace_prohibited_o) else $error("NS traced");
  AST_KERNEL_ALLOW: assert property (up && $past(enable_i && world_select_i
    && buffer_security_owner_i[1] && !host_trap_general_i && pe_nonsecure_i
    && pe_level_i == 2'h1) |-> trace_prohibited_o == !$past(kernel_level_trace_allow_i))
    else $error("EL1 allow ignored");
  AST_DROP: assert property (up && trc_valid_i && !enable_i |-> s_drop)
    else $error("disabled trace not discarded");
  AST_HOLD: assert property (wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o))
    else $error("stalled word changed");
endmodule : tbo_top_props

bind tbo_top tbo_top_props #(.DATA_W(DATA_W)) u_tbo_top_props (.*);

/* tbo_top_tb_top.sv */
// Self-checking bench for the trace buffer owner decode and intake.
// Assumes the trace unit model and the checker bound into the top.
`timescale 1ns/100ps
module tbo_top_tb_top;
  localparam int          DW   = 64;
  localparam int          TW   = 16;
  localparam logic [15:0] KTAG = 16'h1a2b;
  localparam logic [15:0] HTAG = 16'h3c4d;
  logic clk_sys_i, rst_n_i, ce_i, enable_i, el3_present_i, el2_present_i, pe_nonsecure_i;
  logic [1:0] pe_level_i, buffer_security_owner_i, buffer_level_owner_i, addr_kind_o;
  logic pointer_phys_select_i, stage2_on_i, host_trap_general_i, host_el2_mode_i;
  logic secure_hyp_enable_i, world_select_i, secure_trace_enable_i, lost;
  logic hyp_level_trace_allow_i, kernel_level_trace_allow_i;
  logic user_level_host_trace_allow_i, user_level_trace_allow_i;
  logic [TW-1:0] kernel_addr_space_tag_i, hyp_addr_space_tag_i, vm_tag_i;
  logic [TW-1:0] addr_space_tag_o, vm_tag_o;
  logic trc_valid_i, trc_ready_o, wr_valid_o, wr_ready_i;
  logic [DW-1:0] trc_data_i, wr_data_o;
  logic [DW-1:0] got_q[$];
  logic [2:0] regime_o;
  logic owner_nonsecure_o, owner_el2_o, stage1_on_o, stage2_xlat_o, world_mismatch_o;
  logic [3:0] level_allow_o;
  logic trace_prohibited_o, xlat_prefetch_allow_o, alt_route_allow_o, discard_o;
  int errors, cmp_count, drops;

  tbo_top #(.DATA_W(DW), .TAG_W(TW)) u_tbo_top (.*);
  tbo_trc_src #(.W(DW)) u_tbo_trc_src (.clk_sys_i(clk_sys_i),
    .alt_route_allow_i(alt_route_allow_o), .trc_ready_i(trc_ready_o),
    .trc_valid_o(trc_valid_i), .trc_data_o(trc_data_i), .alt_valid_o(), .lost_o(lost));

  always #25 clk_sys_i = ~clk_sys_i;

  // Writer side: collect words, count discards
  always @(posedge clk_sys_i) begin
    if (wr_valid_o === 1'b1 && wr_ready_i) got_q.push_back(wr_data_o);
    if (discard_o === 1'b1) drops++;
  end

  // ********
  // Tasks
  // ********
  task automatic cmp(input logic [63:0] g, input logic [63:0] e);
    cmp_count++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask : cmp

  task automatic end_sim();
    $display("comparisons %0d errors %0d", cmp_count, errors);
    if (errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Owner decode; world follows owner unless mm; rg, ak are package codes
  task automatic dec(input logic e, input logic [1:0] so, lo, input logic h2, m2, pv, mm,
                     input logic [2:0] rg, input logic [1:0] ak, input logic [15:0] tg,
                     input logic s2);
    enable_i = e;
    buffer_security_owner_i = so;
    buffer_level_owner_i = lo;
    secure_hyp_enable_i = h2;
    host_el2_mode_i = m2;
    pointer_phys_select_i = pv;
    world_select_i = so[1] ^ mm;
    @(posedge clk_sys_i);
    #1;
    cmp(regime_o, rg);
    cmp(addr_kind_o, ak);
    cmp(addr_space_tag_o, tg);
    cmp(stage2_xlat_o, s2);
    cmp(world_mismatch_o, mm);
    cmp(vm_tag_o, s2 ? 16'h0055 : 16'h0000);
    cmp(owner_nonsecure_o, e & so[1]);
  endtask : dec

  task automatic prh(input logic ns, input logic [1:0] l, input logic ex);
    pe_nonsecure_i = ns;
    pe_level_i     = l;
    @(posedge clk_sys_i);
    #1;
    cmp(trace_prohibited_o, ex);
  endtask : prh

  // Hang guard; the run needs well under a hundred cycles
  initial begin
    repeat (3000) @(posedge clk_sys_i);
    errors++;
    end_sim();
  end

  // ********
  // Main sequence
  // ********
  initial begin
    {clk_sys_i, rst_n_i, enable_i, pointer_phys_select_i, host_trap_general_i} = '0;
    {host_el2_mode_i, secure_hyp_enable_i, wr_ready_i, world_select_i} = '0;
    {buffer_security_owner_i, buffer_level_owner_i, pe_level_i} = {2'h2, 2'h2, 2'h1};
    {ce_i, el3_present_i, el2_present_i, pe_nonsecure_i, stage2_on_i} = '1;
    {secure_trace_enable_i, hyp_level_trace_allow_i, kernel_level_trace_allow_i} = '1;
    {user_level_host_trace_allow_i, user_level_trace_allow_i} = '1;
    kernel_addr_space_tag_i = KTAG;
    hyp_addr_space_tag_i    = HTAG;
    vm_tag_i                = 16'h0055;
    repeat (12) @(posedge clk_sys_i);
    #1;
    rst_n_i = 1'b1;
    repeat (3) @(posedge clk_sys_i);
    #1;
    dec(0, 2, 0, 0, 0, 0, 0, 0, 0, 0, 0);
    cmp(xlat_prefetch_allow_o, 0);
    dec(1, 0, 0, 0, 0, 0, 0, 1, 1, KTAG, 0);
    dec(1, 1, 0, 1, 0, 0, 0, 2, 1, 0, 0);
    dec(1, 0, 0, 1, 1, 0, 0, 3, 1, HTAG, 0);
    dec(1, 0, 2, 1, 1, 0, 0, 1, 1, KTAG, 1);
    dec(1, 2, 0, 0, 0, 0, 0, 5, 1, 0, 0);
    dec(1, 3, 0, 0, 1, 0, 0, 6, 1, HTAG, 0);
    dec(1, 2, 3, 0, 1, 0, 0, 4, 1, KTAG, 1);
    dec(1, 2, 2, 0, 0, 1, 0, 4, 2, 0, 1);
    dec(1, 2, 0, 0, 1, 1, 0, 6, 3, 0, 0);
    el2_present_i = 1'b0;
    dec(1, 2, 0, 0, 0, 0, 0, 4, 1, KTAG, 0);
    el2_present_i = 1'b1;
    stage2_on_i   = 1'b0;
    dec(1, 3, 2, 0, 0, 0, 1, 4, 1, KTAG, 0);
    stage2_on_i    = 1'b1;
    world_select_i = 1'b1;
    prh(1, 3, 1);
    prh(1, 2, 1);
    prh(1, 1, 0);
    kernel_level_trace_allow_i = 1'b0;
    prh(1, 1, 1);
    kernel_level_trace_allow_i = 1'b1;
    prh(1, 0, 0);
    user_level_trace_allow_i = 1'b0;
    prh(1, 0, 1);
    prh(0, 1, 1);
    host_trap_general_i = 1'b1;
    user_level_trace_allow_i = 1'b1;
    prh(1, 0, 1);
    buffer_level_owner_i = 2'h0;
    prh(1, 0, 0);
    prh(1, 2, 0);
    {user_level_host_trace_allow_i, hyp_level_trace_allow_i} = 2'b00;
    prh(1, 0, 1);
    prh(1, 2, 1);
    {host_trap_general_i, buffer_security_owner_i, buffer_level_owner_i} = {1'b0, 2'h0, 2'h2};
    world_select_i = 1'b0;
    prh(0, 1, 0);
    prh(1, 1, 1);
    secure_trace_enable_i = 1'b0;
    prh(0, 1, 1);
    {secure_trace_enable_i, world_select_i} = 2'b11;
    prh(0, 1, 1);
    buffer_security_owner_i = 2'h2;
    prh(1, 1, 0);
    cmp(level_allow_o, 4'h3);
    // Fill the two-entry buffer with the writer stalled, then drain it
    fork
      u_tbo_trc_src.send_n(64'h0123_4567_89ab_cde0, 3);
      begin
        repeat (4) @(posedge clk_sys_i);
        #1;
        cmp(trc_ready_o, 0);
        cmp(wr_valid_o, 1);
        wr_ready_i = 1'b1;
      end
    join
    repeat (4) @(posedge clk_sys_i);
    #1;
    cmp(got_q.size(), 3);
    for (int i = 0; i < 3; i++) cmp(got_q[i], 64'h0123_4567_89ab_cde0 + 64'(i));
    cmp(wr_valid_o, 0);
    enable_i = 1'b0;
    @(posedge clk_sys_i);
    #1;
    u_tbo_trc_src.send_n(64'hfeed_0000_0000_0000, 2);
    cmp(alt_route_allow_o, 1);
    @(posedge clk_sys_i) #1;
    enable_i   = 1'b1;
    pe_level_i = 2'h3;
    u_tbo_trc_src.send_n(64'hbeef_0000_0000_0000, 1);
    repeat (3) @(posedge clk_sys_i);
    #1;
    cmp(drops, 3);
    cmp(got_q.size(), 3);
    cmp(lost, 0);
    end_sim();
  end
endmodule : tbo_top_tb_top

/* tbo_trc_src.sv */
// Behavioural trace unit that feeds words into the buffer intake.
// Assumes the bench clock; the external route sink is left open.
`timescale 1ns/100ps
module tbo_trc_src #(
  parameter int W = 64
) (
  input  wire logic         clk_sys_i,
  input  wire logic         alt_route_allow_i,
  input  wire logic         trc_ready_i,
  output logic              trc_valid_o,
  output logic      [W-1:0] trc_data_o,
  output logic              alt_valid_o,
  output logic              lost_o
);
  // ********
  // Intake driver
  // ********
  // Idle values at time zero
  initial begin
    trc_valid_o = 1'b0;
    trc_data_o  = '0;
    lost_o      = 1'b0;
  end

  assign alt_valid_o = trc_valid_o & alt_route_allow_i;

  // Ready sampled mid-cycle; a stuck word sets lost_o, no hang
  task automatic send_n(input logic [W-1:0] base, input int n);
    logic r;
    int   k;
    for (int i = 0; i < n; i++) begin
      trc_valid_o = 1'b1;
      trc_data_o  = base + W'(i);
      k = 0;
      do begin
        @(negedge clk_sys_i);
        r = trc_ready_i;
        @(posedge clk_sys_i);
        #1;
        k++;
      end while (!r && k < 40);
      lost_o = lost_o | !r;
    end
    trc_valid_o = 1'b0;
    // Released data never keeps the last word
    trc_data_o  = ~trc_data_o;
  endtask : send_n
endmodule : tbo_trc_src
